// ===== shared/blpwm_consts.svh
`ifndef BLPWM_CONSTS_SVH
`define BLPWM_CONSTS_SVH
// ==========================================================================
// Register map, byte addresses.
`define BLPWM_ADDR_CFG_MD 8'h00
`define BLPWM_ADDR_CFG_AD 8'h04
`define BLPWM_ADDR_CFG_KP 8'h08
`define BLPWM_ADDR_STATUS 8'h0C
// ==========================================================================
// Field positions in a channel configuration word.
`define BLPWM_DUTY_LSB 0
`define BLPWM_DUTY_MSB 5
`define BLPWM_LEVEL_LSB 8
`define BLPWM_LEVEL_MSB 10
`define BLPWM_HI_BIT 11
`define BLPWM_RAMP_BIT 12
`define BLPWM_CFG_RESET 32'h0000_0000
// ==========================================================================
// Timing.
`define BLPWM_CLK_HZ 250000000
`define BLPWM_PWM_HZ 256
`define BLPWM_STEPS_PER_PERIOD 32
`define BLPWM_RAMP_HZ 64
`define BLPWM_DUTY_FULL 6'h20
// Least on-time stretch, in PWM slots, covering boost start-up.
`define BLPWM_MIN_ON_SLOTS 5'h10
// Time-share slot length is one PWM slot: 8 kHz alternation.
`define BLPWM_SLOT_CYCLES \
  (`BLPWM_CLK_HZ / (`BLPWM_PWM_HZ * `BLPWM_STEPS_PER_PERIOD))
`define BLPWM_RAMP_SLOTS \
  (`BLPWM_PWM_HZ * `BLPWM_STEPS_PER_PERIOD / `BLPWM_RAMP_HZ)
`define BLPWM_RESP_OKAY 2'h0
`define BLPWM_RESP_DECERR 2'h3
`endif

// ===== shared/blpwm_pkg.sv
package blpwm_pkg;
  typedef struct packed {
    logic ramp;
    logic hiRange;
    logic [2:0] level;
    logic [5:0] duty;
  } blpwm_cfg_t;

  typedef struct packed {
    logic on;
    logic [3:0] currentLevel;
  } blpwm_drive_t;
endpackage : blpwm_pkg

// ===== rtl/blpwm_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "blpwm_consts.svh"
// ==========================================================================
// Reference divider: one slot pulse every 1/8192 s, a 5-bit slot phase
// within the 256 Hz PWM period, and one ramp tick every 1/64 s.
module blpwm_tick_gen
  import blpwm_pkg::*;
#(
  parameter int SLOT_CYCLES = `BLPWM_SLOT_CYCLES,
  parameter int RAMP_SLOTS = `BLPWM_RAMP_SLOTS
) (
  input wire logic clk_sys,
  input wire logic reset,
  output logic slotTick,
  output logic [4:0] slotPhase,
  output logic rampTick
);
  logic [15:0] divCnt_q;
  logic [7:0] rampCnt_q;
  wire divWrap = (divCnt_q == 16'(SLOT_CYCLES - 1));
  wire rampWrap = (rampCnt_q == 8'(RAMP_SLOTS - 1));

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      divCnt_q <= 16'h0000;
      rampCnt_q <= 8'h00;
      slotPhase <= 5'h00;
      slotTick <= 1'b0;
      rampTick <= 1'b0;
    end else begin
      divCnt_q <= divWrap ? 16'h0000 : divCnt_q + 16'h0001;
      slotTick <= divWrap;
      rampTick <= divWrap && rampWrap;
      if (divWrap) begin
        slotPhase <= slotPhase + 5'h01;
        rampCnt_q <= rampWrap ? 8'h00 : rampCnt_q + 8'h01;
      end
    end
  end
endmodule : blpwm_tick_gen
`default_nettype wire

// ===== rtl/blpwm_ramp.sv
`timescale 1ns/1ps
`default_nettype none
`include "blpwm_consts.svh"
// ==========================================================================
// Applied-duty tracker for one channel.
module blpwm_ramp
  import blpwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [5:0] target,
  input wire logic rampEnable,
  input wire logic rampTick,
  output logic [5:0] applied
);
  // Codes 32..63 all mean full on, so the ramp aims at 32.
  wire [5:0] aim = target[5] ? `BLPWM_DUTY_FULL : target;
  wire [5:0] cur = applied[5] ? `BLPWM_DUTY_FULL : applied;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      applied <= 6'h00;
    end else if (!rampEnable) begin
      applied <= target;
    end else if (rampTick && cur != aim) begin
      // Retargeting simply continues from the present value.
      applied <= (cur < aim) ? cur + 6'h01 : cur - 6'h01;
    end else if (cur == aim) begin
      applied <= target;
    end
  end
endmodule : blpwm_ramp
`default_nettype wire

// ===== rtl/blpwm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "blpwm_consts.svh"
// Overview of operation
// - Three independent channels: main display, auxiliary display, keypad.
// - Level code times 3 mA low range, times 6 mA high range.
// - Duty code/32 for 0..31; 0 off; 32..63 continuously on.
// - Below full duty, switch at 256 Hz with 1/32 granularity.
// - Stretch on time to cover boost start-up, to half period.
// - Each channel's own ramp enable alone decides ramping.
// - Ramp steps applied duty by 1/32 every 1/64 second.
// - Ramp enable set: every duty write starts a ramp.
// - Ramp enable clear: written duty applies immediately.
// - Channel is enabled whenever its duty is not zero.
// - All three enabled: none is driven.
// - Two enabled: alternate them half the time each, quickly.
// - While sharing, double each active channel's current.
module blpwm_top
  import blpwm_pkg::*;
#(
  parameter int SLOT_CYCLES = `BLPWM_SLOT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2:0] sinkOn,
  output logic [14:0] sinkLevel
);
  // ==========================================================================
  // Register file.
  blpwm_cfg_t cfg_q [3];
  logic [7:0] awAddr_q;
  logic awHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wHeld_q;

  wire wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
  wire [1:0] wrIdx = awAddr_q[3:2];
  wire wrHit = (awAddr_q[7:4] == 4'h0) && (wrIdx != 2'h3) &&
    (awAddr_q[1:0] == 2'h0);
  wire rdHit = (s_axi_araddr[7:4] == 4'h0) && (s_axi_araddr[1:0] == 2'h0);
  wire [1:0] rdIdx = s_axi_araddr[3:2];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BLPWM_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `BLPWM_RESP_OKAY : `BLPWM_RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++) begin : g_cfg
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          cfg_q[gc] <= '0;
        end else if (wrFire && wrHit && wrIdx == 2'(gc)) begin
          if (wStrb_q[0]) begin
            cfg_q[gc].duty <= wData_q[`BLPWM_DUTY_MSB:`BLPWM_DUTY_LSB];
          end
          if (wStrb_q[1]) begin
            cfg_q[gc].level <= wData_q[`BLPWM_LEVEL_MSB:`BLPWM_LEVEL_LSB];
            cfg_q[gc].hiRange <= wData_q[`BLPWM_HI_BIT];
            cfg_q[gc].ramp <= wData_q[`BLPWM_RAMP_BIT];
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Timing and ramps.
  logic slotTick;
  logic [4:0] slotPhase;
  logic rampTick;
  logic [5:0] applied [3];

  blpwm_tick_gen #(
    .SLOT_CYCLES(SLOT_CYCLES),
    .RAMP_SLOTS(`BLPWM_RAMP_SLOTS)
  ) u_tick (
    .clk_sys(clk_sys),
    .reset(reset),
    .slotTick(slotTick),
    .slotPhase(slotPhase),
    .rampTick(rampTick)
  );

  generate
    for (gc = 0; gc < 3; gc++) begin : g_ramp
      blpwm_ramp u_ramp (
        .clk_sys(clk_sys),
        .reset(reset),
        .target(cfg_q[gc].duty),
        .rampEnable(cfg_q[gc].ramp),
        .rampTick(rampTick),
        .applied(applied[gc])
      );
    end
  endgenerate

  // ==========================================================================
  // Arbitration and drive.
  wire [2:0] enabled;
  wire [2:0] pwmOn;
  wire [14:0] levelNext;
  generate
    for (gc = 0; gc < 3; gc++) begin : g_pwm
      wire [5:0] d = applied[gc];
      // The boost needs half a period to start, so a short nonzero
      // duty is stretched to the least on time; brightness at low codes
      // then comes mostly from the level setting.
      wire [4:0] onSlots = (d[4:0] < `BLPWM_MIN_ON_SLOTS) ?
        `BLPWM_MIN_ON_SLOTS : d[4:0];
      assign enabled[gc] = (cfg_q[gc].duty != 6'h00);
      assign pwmOn[gc] = d[5] || ((d != 6'h00) && slotPhase < onSlots);
      // Code times 3 mA, or times 6 mA in high range: one unit is 3 mA.
      assign levelNext[gc*5 +: 5] = cfg_q[gc].hiRange ?
        {1'b0, cfg_q[gc].level, 1'b0} : {2'b00, cfg_q[gc].level};
    end
  endgenerate

  wire allThree = &enabled;
  wire sharing = (enabled == 3'b011) || (enabled == 3'b101) ||
    (enabled == 3'b110);
  // The lower-numbered enabled channel owns even slots.
  wire [2:0] lowPick = enabled & ~(enabled - 3'b001);
  wire [2:0] shareSel = slotPhase[0] ? (enabled & ~lowPick) : lowPick;
  wire [2:0] grant = allThree ? 3'b000 : (sharing ? shareSel : enabled);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sinkOn <= 3'b000;
      sinkLevel <= 15'h0000;
    end else if (slotTick) begin
      sinkOn <= grant & pwmOn;
      // A high-range code doubled again while sharing reaches 28 units, hence five bits per channel.
      sinkLevel <= sharing ? {levelNext[13:10], 1'b0, levelNext[8:5], 1'b0,
        levelNext[3:0], 1'b0} : levelNext;
    end
  end

  // ==========================================================================
  // Read channel: configuration words and a live status word.
  wire [31:0] cfgWord = (rdIdx == 2'h3) ? 32'h0000_0000 :
    {19'h00000, cfg_q[rdIdx].ramp, cfg_q[rdIdx].hiRange,
     cfg_q[rdIdx].level, 2'h0, cfg_q[rdIdx].duty};
  wire [31:0] statWord = {8'h00, 2'h0, applied[2], 2'h0, applied[1],
    2'h0, applied[0]};
  wire [31:0] stat2 = {statWord[31:28], 1'b0, sharing, allThree, sinkOn,
    statWord[21:0]};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BLPWM_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rdHit ? `BLPWM_RESP_OKAY : `BLPWM_RESP_DECERR;
        s_axi_rdata <= !rdHit ? 32'h0000_0000 :
          (rdIdx == 2'h3 ? stat2 : cfgWord);
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : blpwm_top
`default_nettype wire

// ===== dv/blpwm_led_load.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// LED string load: integrates on-time and keeps the last drive level.
module blpwm_led_load
  import blpwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic clear,
  input wire logic [2:0] sinkOn,
  input wire logic [14:0] sinkLevel,
  output logic [2:0][15:0] onCount_q,
  output logic [2:0][4:0] levelSeen_q
);
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < 3; c++) begin
      if (clear) begin
        onCount_q[c] <= 16'h0;
        levelSeen_q[c] <= 5'h00;
      end else if (sinkOn[c]) begin
        onCount_q[c] <= onCount_q[c] + 16'h1;
        levelSeen_q[c] <= sinkLevel[5 * c +: 5];
      end
    end
  end
endmodule : blpwm_led_load
`default_nettype wire

// ===== dv/blpwm_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port properties; sinkOn may only move on slot boundaries.
module blpwm_checker
  import blpwm_pkg::*;
#(
  parameter int SLOT_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [2:0] sinkOn,
  input wire logic [14:0] sinkLevel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [15:0] holdCnt_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) holdCnt_q <= 16'hFFFF;
    else if ($changed(sinkOn)) holdCnt_q <= 16'h0;
    else if (holdCnt_q != 16'hFFFF) holdCnt_q <= holdCnt_q + 16'h1;
  end
  a_one_sink: assert property ($onehot0(sinkOn)) else
    $error("two sinks on together");
  a_slot_hold: assert property ($changed(sinkOn) |->
    32'(holdCnt_q) >= SLOT_CYCLES - 1) else $error("sink moved mid-slot");
  a_level_range: assert property (sinkLevel[4:0] <= 5'h1C &&
    sinkLevel[9:5] <= 5'h1C && sinkLevel[14:10] <= 5'h1C)
    else $error("level out of range");
  a_reset_quiet: assert property ($fell(reset) |->
    sinkOn == 3'h0 && sinkLevel == 15'h0) else $error("drive after reset");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no read answer");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
endmodule : blpwm_checker
bind blpwm_top blpwm_checker #(.SLOT_CYCLES(SLOT_CYCLES)) u_blpwm_checker (
  .clk_sys, .reset, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .sinkOn, .sinkLevel);
`default_nettype wire

// ===== dv/blpwm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "blpwm_consts.svh"
module blpwm_top_tb
  import blpwm_pkg::*;
;
  localparam int SLOT = 4;
  localparam int PER = SLOT * 32;
  localparam int STEP = SLOT * 128;
  localparam logic [1:0] OK = `BLPWM_RESP_OKAY;
  localparam logic [1:0] BAD = `BLPWM_RESP_DECERR;
  typedef struct packed {
    logic [2:0][31:0] cfg;
    logic [2:0][15:0] onExp;
    logic [2:0][4:0] lvlExp;
  } blpwm_row_t;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic [2:0] sinkOn;
  logic [14:0] sinkLevel;
  logic loadClear = 1'b1;
  logic [2:0][15:0] onCount;
  logic [2:0][4:0] levelSeen;
  int miscompares = 0, n_compared = 0, cycles = 0;
  blpwm_row_t rows [7];
  always #2 clk_sys = ~clk_sys;
  blpwm_top #(.SLOT_CYCLES(SLOT)) u_blpwm_top (.clk_sys, .reset,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sinkOn,
    .sinkLevel);
  blpwm_led_load u_blpwm_led_load (.clk_sys, .clear(loadClear), .sinkOn,
    .sinkLevel, .onCount_q(onCount), .levelSeen_q(levelSeen));
  // ====================
  // Helpers. Ready is raised only after valid is seen, so holds get tested.
  function automatic logic [31:0] word(input logic [5:0] d,
    input logic [2:0] l, input logic h, input logic r);
    return {19'h0, r, h, l, 2'h0, d};
  endfunction : word
  task automatic check(input string what, input logic [31:0] e,
    input logic [31:0] got);
    n_compared++;
    if (got !== e) begin
      miscompares++;
      $display("unexpected %s: expected %0h, seen %0h", what, e, got);
    end
  endtask : check
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    check("bresp", 32'(er), 32'(s_axi_bresp));
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd = s_axi_rdata;
    check("rresp", 32'(er), 32'(s_axi_rresp));
    s_axi_rready <= 1'b0;
  endtask : axi_read
  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ====================
  // Main sequence.
  initial begin
    rows[0] = '{{32'h0, 32'h0, word(6'h08, 3'h5, 1'b0, 1'b0)},
      {16'h0, 16'h0, 16'h100}, {5'h00, 5'h00, 5'h05}};
    rows[1] = '{{32'h0, 32'h0, word(6'h14, 3'h3, 1'b1, 1'b0)},
      {16'h0, 16'h0, 16'h140}, {5'h00, 5'h00, 5'h06}};
    rows[2] = '{{32'h0, word(6'h28, 3'h7, 1'b0, 1'b0), 32'h0},
      {16'h0, 16'h200, 16'h0}, {5'h00, 5'h07, 5'h00}};
    rows[3] = '{{word(6'h1F, 3'h1, 1'b1, 1'b0), 32'h0, 32'h0},
      {16'h1F0, 16'h0, 16'h0}, {5'h02, 5'h00, 5'h00}};
    rows[4] = '{{word(6'h20, 3'h3, 1'b0, 1'b0), 32'h0,
      word(6'h3F, 3'h2, 1'b0, 1'b0)}, {16'h100, 16'h0, 16'h100},
      {5'h06, 5'h00, 5'h04}};
    rows[5] = '{{word(6'h20, 3'h5, 1'b0, 1'b0),
      word(6'h20, 3'h7, 1'b1, 1'b0), 32'h0}, {16'h100, 16'h100, 16'h0},
      {5'h0A, 5'h1C, 5'h00}};
    rows[6] = '{{3{word(6'h01, 3'h1, 1'b0, 1'b0)}}, 48'h0, 15'h0000};
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a < 4; a++) begin
      axi_read(8'(4 * a), OK);
      check("reset value", 32'h0, rd);
    end
    for (int i = 0; i < 7; i++) begin
      for (int c = 0; c < 3; c++) axi_write(8'(4 * c), rows[i].cfg[c], OK);
      repeat (2 * PER) @(posedge clk_sys);
      loadClear <= 1'b0;
      repeat (4 * PER) @(posedge clk_sys);
      loadClear <= 1'b1;
      @(posedge clk_sys);
      for (int c = 0; c < 3; c++) begin
        check("on time", 32'(rows[i].onExp[c]), 32'(onCount[c]));
        if (rows[i].onExp[c] != 16'h0) check("level", 32'(rows[i].lvlExp[c]), 32'(levelSeen[c]));
      end
      $display("row %0d done", i);
    end
    axi_write(`BLPWM_ADDR_CFG_MD, word(6'h18, 3'h1, 1'b0, 1'b1), OK);
    repeat (4 * STEP + STEP / 2) @(posedge clk_sys);
    axi_read(`BLPWM_ADDR_STATUS, OK);
    check("ramp", 32'h1, 32'(rd[5:0] inside {[6'h05:6'h06]}));
    axi_write(`BLPWM_ADDR_CFG_MD, word(6'h02, 3'h1, 1'b0, 1'b1), OK);
    axi_read(`BLPWM_ADDR_STATUS, OK);
    check("retarget", 32'h1, 32'(rd[5:0] inside {[6'h04:6'h07]}));
    repeat (6 * STEP) @(posedge clk_sys);
    axi_read(`BLPWM_ADDR_STATUS, OK);
    check("ramp end", 32'h02, 32'(rd[5:0]));
    axi_write(`BLPWM_ADDR_CFG_AD, word(6'h00, 3'h0, 1'b0, 1'b1), OK);
    axi_write(`BLPWM_ADDR_CFG_MD, word(6'h1E, 3'h1, 1'b0, 1'b0), OK);
    repeat (2 * SLOT) @(posedge clk_sys);
    axi_read(`BLPWM_ADDR_STATUS, OK);
    check("direct", 32'h1E, 32'(rd[5:0]));
    $display("ramp test done");
    axi_read(8'h10, BAD);
    check("unmapped", 32'h0, rd);
    axi_read(8'h02, BAD);
    axi_write(`BLPWM_ADDR_STATUS, 32'h0, BAD);
    s_axi_wstrb <= 4'h2;
    axi_write(`BLPWM_ADDR_CFG_KP, word(6'h3F, 3'h5, 1'b1, 1'b0), OK);
    s_axi_wstrb <= 4'hF;
    axi_read(`BLPWM_ADDR_CFG_KP, OK);
    check("strobe", word(6'h01, 3'h5, 1'b1, 1'b0), rd);
    $display("bus error test done");
    reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    axi_read(`BLPWM_ADDR_STATUS, OK);
    check("after reset", 32'h0, rd);
    $display("reset test done");
    tally_and_finish();
  end
endmodule : blpwm_top_tb
`default_nettype wire
